// file: rtl/bss_defines.svh
// Constants for the burst synchronous memory front end
`ifndef BSS_DEFINES_SVH
`define BSS_DEFINES_SVH
`define BSS_LANE_W 9
`define BSS_CNT_W 2
`define BSS_FIFO_DEPTH 8
`define BSS_CTRL_OFF 12'h000
`define BSS_STAT_OFF 12'h004
`define BSS_CTRL_RST 1'b0
`define BSS_ERR_DATA 32'h0000_0000
`endif

// file: rtl/bss_front_end.sv
// Burst synchronous memory front end with write FIFO and APB status
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "bss_defines.svh"

// Write FIFO between the sampled pins and the array
module bss_fifo #(
  parameter int W = 8,
  parameter int DEPTH = `BSS_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } bss_fifo_s;

  bss_fifo_s s_r;
  bss_fifo_s s_nxt;
  logic [W-1:0] buf_mem [0:DEPTH-1];
  logic push;
  logic pop;

  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH) $error("bss_fifo: DEPTH must be a power of two");
  end

  // Honest flags straight from the count
  assign in_ready = (s_r.cnt != (PW+1)'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data = buf_mem[s_r.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer and count update
  always_comb begin
    s_nxt = s_r;
    if (push) s_nxt.wp = PW'(s_r.wp + 1'b1);
    if (pop) s_nxt.rp = PW'(s_r.rp + 1'b1);
    s_nxt.cnt = (PW+1)'(s_r.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk) begin
    if (push) buf_mem[s_r.wp] <= in_data;
  end
endmodule : bss_fifo

// How it works
// - A two-bit counter holds the burst position, clears on a strobe and steps each advance beat
// - Every synchronous input is sampled on the rising edge of REF_CLK
// - Address, data, enables, strobes, advance and write controls are all sampled
// - Output enable and sleep act on the data drivers without the clock
// - Burst order input high gives interleaved order, low gives linear order
// - Either address strobe starts a new burst
// - Address and enables are captured on a strobe edge, held otherwise
// - Later beats advance only while burst advance is asserted
// - First read data after two edges, each further beat after one
// - Sampled writes complete internally through the write FIFO
// - Built as 512K x 36 or 1M x 18 with shared data pins
// - Single-enable variant selects on the pipelined enable alone
module bss_front_end #(
  parameter bit WIDE = 1'b1,
  parameter int DW = WIDE ? 36 : 18,
  parameter int AW = WIDE ? 19 : 20,
  parameter int FIFO_DEPTH = `BSS_FIFO_DEPTH
) (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic [AW-1:0] ADDR,
  input wire logic [DW-1:0] DATA_IN,
  output logic [DW-1:0] DATA_OUT,
  output logic DATA_OE,
  input wire logic PIPELINED_SELECT_N,
  input wire logic DEPTH_SELECT_HI,
  input wire logic DEPTH_SELECT_N,
  input wire logic CPU_ADDR_STROBE_N,
  input wire logic CTRL_ADDR_STROBE_N,
  input wire logic BURST_ADVANCE_N,
  input wire logic [DW/`BSS_LANE_W-1:0] LANE_WRITE_N,
  input wire logic LANE_WRITE_ENABLE_N,
  input wire logic ALL_LANES_WRITE_N,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic SLEEP_REQUEST,
  input wire logic BURST_ORDER_INTERLEAVE,
  output logic WR_READY,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  localparam int LANES = DW / `BSS_LANE_W;
  localparam int FW = AW + LANES + DW;

  initial begin
    if (DW != LANES * `BSS_LANE_W || AW < 3) $error("bss_front_end: bad geometry");
  end

  typedef struct packed {
    logic [AW-1:0] base;
    logic [`BSS_CNT_W-1:0] cnt;
    logic sel;
    logic act;
    bss_pkg::bss_state_e st;
    logic [AW-1:0] raddr;
    logic [DW-1:0] dout;
    logic drv;
    logic single;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } bss_top_s;

  bss_top_s s_r;
  bss_top_s s_nxt;
  logic [DW-1:0] mem [0:(1<<AW)-1];

  logic strobe;
  logic awake;
  logic sel_now;
  logic advance;
  logic beat;
  logic wr_req;
  logic [LANES-1:0] lanes;
  logic [`BSS_CNT_W-1:0] cnt_inc;
  logic [AW-1:0] beat_addr;
  logic push_valid;
  logic [FW-1:0] f_out;
  logic f_valid;
  logic apb_acc;

  // Burst order of one beat within the four-beat group
  function automatic logic [1:0] burst_lo(input logic il, input logic [1:0] start,
                                          input logic [1:0] k);
    burst_lo = il ? (start ^ k) : 2'(start + k);
  endfunction : burst_lo

  // Chip select decode, full or single-enable variant
  function automatic logic chip_sel(input logic single, input logic pipe_n,
                                    input logic dep_hi, input logic dep_n);
    chip_sel = single ? ~pipe_n : (~pipe_n & dep_hi & ~dep_n);
  endfunction : chip_sel

  // Decode of the pins sampled at this edge
  assign awake = ~SLEEP_REQUEST;
  assign strobe = ~CPU_ADDR_STROBE_N | ~CTRL_ADDR_STROBE_N;
  assign sel_now = chip_sel(s_r.single, PIPELINED_SELECT_N,
                            DEPTH_SELECT_HI, DEPTH_SELECT_N);
  assign advance = ~BURST_ADVANCE_N & s_r.act & ~strobe;
  assign beat = awake & ((strobe & sel_now) | advance);
  assign wr_req = ~ALL_LANES_WRITE_N | (~LANE_WRITE_ENABLE_N & ~&LANE_WRITE_N);
  assign lanes = ~ALL_LANES_WRITE_N ? {LANES{1'b1}} : ~LANE_WRITE_N;
  assign cnt_inc = `BSS_CNT_W'(s_r.cnt + 2'h1);

  // Beat address: pins on a strobe, counter order on advance
  always_comb begin
    if (strobe) begin
      beat_addr = ADDR;
    end else begin
      beat_addr = {s_r.base[AW-1:2],
                   burst_lo(BURST_ORDER_INTERLEAVE, s_r.base[1:0], cnt_inc)};
    end
  end

  assign push_valid = beat & wr_req;
  assign apb_acc = PSEL & PENABLE & ~s_r.pready;

  // Sampled writes queue here and drain while awake
  bss_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .in_valid(push_valid),
    .in_ready(WR_READY),
    .in_data({beat_addr, lanes, DATA_IN}),
    .out_valid(f_valid),
    .out_ready(awake),
    .out_data(f_out)
  );

  // Self timed array write, all enabled lanes at the same edge
  always_ff @(posedge REF_CLK) begin
    if (f_valid && awake) begin
      for (int l = 0; l < LANES; l++) begin
        if (f_out[DW+l]) begin
          mem[f_out[FW-1 -: AW]][l*`BSS_LANE_W +: `BSS_LANE_W] <=
            f_out[l*`BSS_LANE_W +: `BSS_LANE_W];
        end
      end
    end
  end

  // Next state of burst tracking, read path and APB
  always_comb begin
    s_nxt = s_r;
    if (strobe && awake) begin
      s_nxt.base = ADDR;
      s_nxt.sel = sel_now;
      s_nxt.cnt = '0;
      s_nxt.act = sel_now;
    end else if (advance && awake) begin
      s_nxt.cnt = cnt_inc;
    end
    if (beat) begin
      s_nxt.st = wr_req ? bss_pkg::BSS_WR : bss_pkg::BSS_RD;
    end else begin
      s_nxt.st = bss_pkg::BSS_IDLE;
    end
    if (beat && !wr_req) s_nxt.raddr = beat_addr;
    // Read data one edge after its beat
    s_nxt.drv = (s_r.st == bss_pkg::BSS_RD);
    if (s_r.st == bss_pkg::BSS_RD) s_nxt.dout = mem[s_r.raddr];
    // APB with one wait state
    s_nxt.pready = apb_acc;
    s_nxt.pslverr = 1'b0;
    if (apb_acc) begin
      case (PADDR)
        `BSS_CTRL_OFF: begin
          if (PWRITE) s_nxt.single = PWDATA[0];
          s_nxt.prdata = {31'h0, s_r.single};
        end
        `BSS_STAT_OFF: begin
          s_nxt.prdata = {27'h0, WR_READY, f_valid, s_r.cnt, s_r.act};
        end
        default: begin
          s_nxt.prdata = `BSS_ERR_DATA;
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end
  end

  // All state registers
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_r <= '{base: '0, cnt: '0, sel: 1'b0, act: 1'b0,
               st: bss_pkg::BSS_IDLE, raddr: '0, dout: '0,
               drv: 1'b0, single: `BSS_CTRL_RST, pready: 1'b0,
               prdata: '0, pslverr: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Drivers released asynchronously by output enable or sleep
  assign DATA_OE = s_r.drv & ~OUTPUT_ENABLE_N & ~SLEEP_REQUEST
                   & (s_r.st != bss_pkg::BSS_WR);
  assign DATA_OUT = s_r.dout;
  assign PRDATA = s_r.prdata;
  assign PREADY = s_r.pready;
  assign PSLVERR = s_r.pslverr;

  // Checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);

  sequence rd_start_s;
    strobe && awake && sel_now && !wr_req;
  endsequence

  sequence rd_beat_s;
    advance && awake && !wr_req;
  endsequence

  cap_addr_a: assert property (strobe && awake |=>
    s_r.base == $past(ADDR) && s_r.cnt == 2'h0 && s_r.sel == $past(sel_now))
    else $error("address not captured on strobe");

  hold_addr_a: assert property (!strobe |=> $stable(s_r.base) && $stable(s_r.sel))
    else $error("address changed without strobe");

  advance_only_a: assert property (!(advance && awake) && !strobe |=> $stable(s_r.cnt))
    else $error("counter moved without advance");

  advance_step_a: assert property (advance && awake |=> s_r.cnt == 2'($past(s_r.cnt) + 2'h1))
    else $error("counter did not step");

  il_order_a: assert property (rd_beat_s and BURST_ORDER_INTERLEAVE |=>
    s_r.raddr[1:0] == ($past(s_r.base[1:0]) ^ 2'($past(s_r.cnt) + 2'h1)))
    else $error("interleaved order wrong");

  lin_order_a: assert property (rd_beat_s and !BURST_ORDER_INTERLEAVE |=>
    s_r.raddr[1:0] == 2'($past(s_r.base[1:0]) + $past(s_r.cnt) + 2'h1))
    else $error("linear order wrong");

  upper_fixed_a: assert property (rd_beat_s |=> s_r.raddr[AW-1:2] == s_r.base[AW-1:2])
    else $error("upper address moved in burst");

  // A read beat just before the strobe still owns the next data cycle
  first_data_a: assert property (rd_start_s and (s_r.st != bss_pkg::BSS_RD) |=>
    !s_r.drv ##1 s_r.drv)
    else $error("first read not after two edges");

  next_data_a: assert property (rd_beat_s |-> ##2 s_r.drv)
    else $error("burst beat not after one edge");

  oe_release_a: assert property (OUTPUT_ENABLE_N || SLEEP_REQUEST
    || s_r.st == bss_pkg::BSS_WR |-> !DATA_OE)
    else $error("data pins driven while released");

  write_push_a: assert property (push_valid && WR_READY |=> f_valid)
    else $error("sampled write not queued");

  single_sel_a: assert property (s_r.single && strobe && awake
    && !PIPELINED_SELECT_N |=> s_r.sel)
    else $error("single enable variant not selected");

  lane_write_a: assert property (strobe && awake && sel_now && !LANE_WRITE_ENABLE_N
    && !(&LANE_WRITE_N) |=> s_r.st == bss_pkg::BSS_WR)
    else $error("lane write not taken as write");

  read_beat_a: assert property (strobe && awake && sel_now && ALL_LANES_WRITE_N
    && (LANE_WRITE_ENABLE_N || (&LANE_WRITE_N)) |=> s_r.st == bss_pkg::BSS_RD)
    else $error("beat without write controls not a read");

  sleep_ignore_a: assert property (SLEEP_REQUEST |=>
    $stable(s_r.base) && $stable(s_r.cnt) && s_r.st == bss_pkg::BSS_IDLE)
    else $error("beat taken while asleep");

  apb_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("apb answer not after one wait");
endmodule : bss_front_end
`default_nettype wire

// file: rtl/bss_pkg.sv
// Types for the burst synchronous memory front end
package bss_pkg;
  typedef enum logic [2:0] {
    BSS_IDLE = 3'b001,
    BSS_RD = 3'b010,
    BSS_WR = 3'b100
  } bss_state_e;
endpackage : bss_pkg

// file: testbench/bss_cpu_model.sv
// Controller model that drives the memory pins one beat per clock
`timescale 1ns/10ps
`default_nettype none
module bss_cpu_model (
  input wire logic clk,
  output logic [18:0] addr,
  output logic [35:0] din,
  output logic cpu_stb_n,
  output logic ctl_stb_n,
  output logic advance_n,
  output logic wr_n
);
  // Idle pins at time zero
  initial begin
    addr = '0;
    din = '0;
    cpu_stb_n = 1'b1;
    ctl_stb_n = 1'b1;
    advance_n = 1'b1;
    wr_n = 1'b1;
  end

  // Kind 1 or 2 starts a burst, 3 advances, 0 idles; data follows d on starts and writes
  task automatic beat(input logic [1:0] k, input logic w, input logic [18:0] a,
                      input logic [35:0] d);
    @(posedge clk);
    cpu_stb_n <= k != 2'h1;
    ctl_stb_n <= k != 2'h2;
    advance_n <= k != 2'h3;
    wr_n <= ~w;
    addr <= (k == 2'h1 || k == 2'h2) ? a : ~addr;
    din <= (w || k == 2'h1 || k == 2'h2) ? d : ~din;
  endtask : beat
endmodule : bss_cpu_model
`default_nettype wire

// file: testbench/burst_sync_sram_front_end_test.sv
// Testbench for the burst synchronous memory front end
`timescale 1ns/10ps
`default_nettype none
module burst_sync_sram_front_end_test;
  logic clk = 1'b0, rst_n = 1'b0, sel_n = 1'b0, dhi = 1'b1, oe_n = 1'b0, mode = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, prdy, pe, perr, doe, wrdy, cs, ps, advance_n, wr;
  logic slp = 1'b0, dsn = 1'b0, lwe_n = 1'b1;
  logic [3:0] lw_n = 4'hf;
  logic [11:0] pa = '0;
  logic [31:0] pwd = '0, prd, rv;
  logic [18:0] ad;
  logic [35:0] din, dout;
  logic [35:0] mem [4];
  int n_fail = 0, compares = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  bss_cpu_model bss_cpu_model_inst (.clk(clk), .addr(ad), .din(din), .cpu_stb_n(ps),
    .ctl_stb_n(cs), .advance_n(advance_n), .wr_n(wr));
  bss_front_end bss_front_end_inst (.REF_CLK(clk), .RESETN(rst_n), .ADDR(ad), .DATA_IN(din),
    .DATA_OUT(dout), .DATA_OE(doe), .PIPELINED_SELECT_N(sel_n), .DEPTH_SELECT_HI(dhi),
    .DEPTH_SELECT_N(dsn), .CPU_ADDR_STROBE_N(ps), .CTRL_ADDR_STROBE_N(cs),
    .BURST_ADVANCE_N(advance_n), .LANE_WRITE_N(lw_n), .LANE_WRITE_ENABLE_N(lwe_n),
    .ALL_LANES_WRITE_N(wr), .OUTPUT_ENABLE_N(oe_n), .SLEEP_REQUEST(slp),
    .BURST_ORDER_INTERLEAVE(mode), .WR_READY(wrdy), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr));

  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Burst order: interleaved flips bits, linear adds modulo four
  function automatic logic [1:0] ord(input logic md, input logic [1:0] s, input logic [1:0] n);
    return md ? (s ^ n) : (s + n);
  endfunction : ord

  // APB transfer; pready, read data and error taken at the rising edge that completes it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rv = prd;
    pe = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic regs;
    apb(1'b0, 12'h000, '0);
    chk("ctrl reset", 36'h0, rv);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h000, '0);
    chk("ctrl back", 36'h1, rv);
    apb(1'b1, 12'h000, '0);
    apb(1'b0, 12'h004, '0);
    chk("status idle", 36'h10, rv);
    apb(1'b0, 12'h800, '0);
    chk("unmapped err", 36'h1, pe);
    chk("unmapped data", 36'h0, rv);
  endtask : regs

  // Four write beats then one idle edge
  task automatic wr4(input logic [1:0] k, input logic md, input logic [18:0] a);
    for (int i = 0; i < 5; i++) begin
      bss_cpu_model_inst.beat(i == 0 ? k : (i < 4 ? 2'h3 : 2'h0), i < 4, a,
                              {a[17:0], 16'h0, i[1:0]});
      if (i == 0) mode <= md;
      if (i < 4) mem[ord(md, a[1:0], i[1:0])] = {a[17:0], 16'h0, i[1:0]};
      #1 chk("write oe", 36'h0, doe);
    end
    chk("wr ready", 36'h1, wrdy);
  endtask : wr4

  // Read burst, optionally with one stalled edge in the middle
  task automatic rd4(input logic [1:0] k, input logic md, input logic [18:0] a, input logic st);
    logic pb, cb, v;
    logic [1:0] n;
    pb = 1'b0;
    cb = 1'b1;
    n = '0;
    bss_cpu_model_inst.beat(k, 1'b0, a, '0);
    mode <= md;
    for (int j = 0; j < 6; j++) begin
      v = st ? (j != 1 && j < 4) : (j < 3);
      bss_cpu_model_inst.beat(v ? 2'h3 : 2'h0, 1'b0, a, '0);
      #1 chk("read oe", {35'h0, pb}, doe);
      if (pb) begin
        chk("read data", mem[ord(md, a[1:0], n)], dout);
        n++;
      end
      pb = cb;
      cb = v;
    end
  endtask : rd4

  // Output enable, then sleep, releases the pins without waiting for a clock edge
  task automatic oe_chk(input logic [18:0] a);
    for (int i = 0; i < 2; i++) begin
      bss_cpu_model_inst.beat(2'h1, 1'b0, a, '0);
      bss_cpu_model_inst.beat(2'h0, 1'b0, a, '0);
      @(posedge clk);
      if (i == 0) oe_n <= 1'b1;
      else slp <= 1'b1;
      #1 chk("oe off", 36'h0, doe);
      @(posedge clk);
      oe_n <= 1'b0;
      slp <= 1'b0;
    end
  endtask : oe_chk

  // Strobe while not selected: no beats follow
  task automatic desel(input logic [18:0] a);
    @(posedge clk);
    sel_n <= 1'b1;
    bss_cpu_model_inst.beat(2'h1, 1'b0, a, '0);
    for (int i = 0; i < 3; i++) begin
      bss_cpu_model_inst.beat(2'h3, 1'b0, a, '0);
      #1 chk("deselected oe", 36'h0, doe);
    end
    bss_cpu_model_inst.beat(2'h0, 1'b0, a, '0);
    sel_n <= 1'b0;
  endtask : desel

  // Lane 0 written through the lane enables, other lanes kept, then read back
  task automatic lane_wr(input logic [18:0] a);
    bss_cpu_model_inst.beat(2'h1, 1'b0, a, 36'hf_ffff_ffff);
    lwe_n <= 1'b0;
    lw_n <= 4'he;
    mem[a[1:0]][8:0] = 9'h1ff;
    bss_cpu_model_inst.beat(2'h0, 1'b0, a, '0);
    lwe_n <= 1'b1;
    lw_n <= 4'hf;
    rd4(2'h1, 1'b0, a, 1'b0);
  endtask : lane_wr

  task automatic complete_run;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // Watchdog against a hung handshake
  initial begin
    #100000;
    n_fail++;
    complete_run;
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("reset oe", 36'h0, doe);
    chk("reset wr ready", 36'h1, wrdy);
    regs;
    wr4(2'h2, 1'b0, 19'h12342);
    rd4(2'h1, 1'b1, 19'h12341, 1'b0);
    rd4(2'h2, 1'b0, 19'h12343, 1'b1);
    oe_chk(19'h12340);
    desel(19'h12340);
    lane_wr(19'h12340);
    apb(1'b1, 12'h000, 32'h1);
    @(posedge clk);
    dhi <= 1'b0;
    dsn <= 1'b1;
    rd4(2'h1, 1'b0, 19'h12340, 1'b0);
    complete_run;
  end
endmodule : burst_sync_sram_front_end_test
`default_nettype wire
